// ---- src/dmc_top.sv ----
// dmc_top: module-wide and per-channel dma control with axi4-lite
// registers, clear/set/invert aliases, channel arbiter and interrupt.
// assumes an external transfer engine that runs the granted channel
// and reports block completion on chan_done_i.
`timescale 1ns/1ps
module dmc_top #(
    parameter int unsigned NCH = 4
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [dmc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic      [1:0]                 s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [dmc_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    input  wire logic [NCH-1:0]             chan_start_i,
    input  wire logic [NCH-1:0]             chan_abort_i,
    input  wire logic [NCH-1:0]             chan_done_i,
    output logic      [NCH-1:0]             chan_grant_o,
    output logic                            module_active_o,
    output logic                            irq_o
);
    localparam int unsigned CW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam logic [3:0]  CH_LAST = 4'(NCH);

    // write and read channel holding and response registers
    logic                      aw_hold;
    logic [dmc_pkg::ADDR_W-1:0] aw_addr;
    logic                      w_hold;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;

    logic                      mod_on;
    logic                      mod_susp;
    logic [NCH-1:0]            cur;
    logic [2*NCH-1:0]          stat;
    logic [2*NCH-1:0]          mask;
    logic [15:0]               ch_ctrl [NCH];
    logic [NCH-1:0]            ch_en;
    logic [NCH-1:0]            ch_det;
    logic [NCH-1:0]            ch_rec;
    logic [NCH-1:0]            chain_trig;

    dmc_arb_if #(.NCH(NCH)) arb_bus ();

    // strobe lanes widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    // index 1..NCH is a channel word
    function automatic logic is_ch(input logic [3:0] idx);
        is_ch = (idx >= dmc_pkg::IDX_CH0) && (idx <= CH_LAST);
    endfunction : is_ch

    // write decode
    wire        do_wr  = aw_hold & w_hold & ~bvalid;
    wire [3:0]  w_idx  = aw_addr[7:4];
    wire [1:0]  w_op   = aw_addr[3:2];
    wire [31:0] smask  = strb_mask(w_strb);
    wire [3:0]  w_chi  = w_idx - dmc_pkg::IDX_CH0;
    wire        w_mod  = w_idx == dmc_pkg::IDX_MOD;
    wire        w_ch   = is_ch(w_idx);
    wire        w_stat = (w_idx == dmc_pkg::IDX_STAT) &&
                         (w_op == dmc_pkg::OP_WR);
    wire        w_mask = w_idx == dmc_pkg::IDX_MASK;
    wire        w_ok   = w_mod | w_ch | w_stat | w_mask;

    // status cannot take aliases: a clear alias there would be ambiguous
    // against the write-one-to-clear meaning, so it answers an error
    wire [31:0] mod_rd = {16'h0000, mod_on, 2'b00, mod_susp,
                          module_active_o, 11'h000};
    wire [31:0] ch_old = {16'h0000, ch_ctrl[w_chi[CW-1:0]]};
    wire [31:0] mod_new = dmc_pkg::alias_apply(mod_rd, w_data, w_op,
                                               smask);
    wire [31:0] ch_new  = dmc_pkg::alias_apply(ch_old, w_data, w_op,
                                               smask);
    wire [31:0] msk_new = dmc_pkg::alias_apply(32'(mask), w_data, w_op,
                                               smask);
    wire [31:0] stat_clr = (do_wr && w_stat) ? (w_data & smask) : '0;

    // read decode
    wire [3:0]  r_idx  = s_axi_araddr[7:4];
    wire [3:0]  r_chi  = r_idx - dmc_pkg::IDX_CH0;
    wire        r_ch   = is_ch(r_idx);
    wire        r_ok   = (r_idx == dmc_pkg::IDX_MOD) | r_ch |
                         (r_idx == dmc_pkg::IDX_STAT) |
                         (r_idx == dmc_pkg::IDX_MASK);
    wire [31:0] r_word =
        (r_idx == dmc_pkg::IDX_MOD)  ? mod_rd :
        r_ch                         ? {16'h0000, ch_ctrl[r_chi[CW-1:0]]} :
        (r_idx == dmc_pkg::IDX_STAT) ? 32'(stat) :
        (r_idx == dmc_pkg::IDX_MASK) ? 32'(mask) : 32'h0000_0000;
    wire        ar_take = s_axi_arvalid & ~rvalid;

    // transfer control
    wire        run     = mod_on & ~mod_susp;
    wire        idle    = ~|cur;
    wire [NCH-1:0] take = arb_bus.grant & {NCH{idle & run}};
    wire        cur_end = |(cur & (chan_done_i | chan_abort_i));

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam int unsigned UP = (g == 0) ? 0 : g - 1;
            localparam int unsigned DN = (g == NCH - 1) ? g : g + 1;
            wire lo_done = (g == NCH - 1) ? 1'b0 : chan_done_i[DN];
            wire hi_done = (g == 0) ? 1'b0 : chan_done_i[UP];
            assign ch_en[g]  = ch_ctrl[g][dmc_pkg::CH_EN];
            assign ch_det[g] = ch_ctrl[g][dmc_pkg::CH_EDET];
            assign ch_rec[g] = ch_en[g] | ch_ctrl[g][dmc_pkg::CH_AED];
            // select 1 follows the next lower-priority neighbour
            assign chain_trig[g] = ch_ctrl[g][dmc_pkg::CH_CSEL] ?
                                   lo_done : hi_done;
            assign arb_bus.req[g] = ch_en[g] & ch_det[g] & run;
            assign arb_bus.prio[2*g +: 2] =
                ch_ctrl[g][dmc_pkg::CH_PRI +: 2];

            dmc_channel u_ch (
                .clk_sys_i    (clk_sys_i),
                .rst_n_i      (rst_n_i),
                .sw_we_i      (do_wr && w_ch && w_chi == 4'(g)),
                .sw_val_i     (ch_new[15:0]),
                .start_i      (chan_start_i[g]),
                .abort_i      (chan_abort_i[g]),
                .done_i       (chan_done_i[g]),
                .chain_trig_i (chain_trig[g]),
                .taken_i      (take[g]),
                .running_i    (cur[g]),
                .ctrl_o       (ch_ctrl[g])
            );
        end
    endgenerate

    dmc_arbiter #(.NCH(NCH)) u_arb (
        .ab (arb_bus.arb)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mod_on   <= 1'b0;
            mod_susp <= 1'b0;
            mask     <= '0;
        end else if (do_wr) begin
            if (w_mod) begin
                mod_on   <= mod_new[dmc_pkg::MOD_ON];
                mod_susp <= mod_new[dmc_pkg::MOD_SUSP];
            end
            if (w_mask) begin
                mask <= msk_new[2*NCH-1:0];
            end
        end
    end

    // the granted channel is dropped at once when the module stops
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cur <= '0;
        end else if (!run || cur_end) begin
            cur <= '0;
        end else if (idle) begin
            cur <= take;
        end
    end

    // sticky events: low half block done, high half recorded abort
    wire [2*NCH-1:0] ev = {chan_abort_i & ch_rec, chan_done_i};
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stat <= '0;
        end else begin
            stat <= ev | (stat & ~stat_clr[2*NCH-1:0]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_hold <= 1'b0;
            aw_addr <= '0;
            w_hold  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= dmc_pkg::RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_wr) begin
                w_hold <= 1'b0;
            end
            if (do_wr) begin
                bvalid <= 1'b1;
                bresp  <= w_ok ? dmc_pkg::RESP_OK : dmc_pkg::RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= dmc_pkg::RESP_OK;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata  <= r_word;
            rresp  <= r_ok ? dmc_pkg::RESP_OK : dmc_pkg::RESP_ERR;
        end else if (s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    assign s_axi_awready   = ~aw_hold;
    assign s_axi_wready    = ~w_hold;
    assign s_axi_bvalid    = bvalid;
    assign s_axi_bresp     = bresp;
    assign s_axi_arready   = ~rvalid;
    assign s_axi_rvalid    = rvalid;
    assign s_axi_rdata     = rdata;
    assign s_axi_rresp     = rresp;
    assign chan_grant_o    = cur;
    assign module_active_o = mod_on | ~idle;
    assign irq_o           = |(stat & mask);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_set_on;
        do_wr && w_mod && w_op == dmc_pkg::OP_SET && w_strb[1] &&
        w_data[dmc_pkg::MOD_ON];
    endsequence
    sequence s_clr_on;
        do_wr && w_mod && w_op == dmc_pkg::OP_CLR && w_strb[1] &&
        w_data[dmc_pkg::MOD_ON];
    endsequence

    a_on_set_alias: assert property (s_set_on |=> mod_on ##1 mod_on)
        else $error("set alias did not enable the module");
    a_alias_clear: assert property (s_clr_on |=> !mod_on)
        else $error("clear alias did not disable the module");
    a_susp_holds: assert property (mod_susp |=> chan_grant_o == '0)
        else $error("grant while suspended");
    a_active_flag: assert property (
        !mod_on ##1 !mod_on |-> !module_active_o)
        else $error("active flag high while off and idle");
    a_mod_rsvd: assert property ((mod_rd & ~dmc_pkg::MOD_IMPL) == '0)
        else $error("reserved module bits not zero");
    a_ch_rsvd: assert property (
        (ch_ctrl[0] & ~dmc_pkg::CH_IMPL) == '0)
        else $error("reserved channel bits not zero");
    a_edet_ro: assert property (
        do_wr && w_ch && w_chi == 4'h0 && !ch_det[0] &&
        !chan_start_i[0] |=> !ch_det[0])
        else $error("software changed event seen flag");
    a_auto_off: assert property (
        chan_done_i[0] && !ch_ctrl[0][dmc_pkg::CH_AUTO] &&
        !(chain_trig[0] && ch_ctrl[0][dmc_pkg::CH_CHN]) |=> !ch_en[0])
        else $error("channel stayed enabled after block done");
    a_chain_on: assert property (
        chain_trig[0] && ch_ctrl[0][dmc_pkg::CH_CHN] |=> ch_en[0])
        else $error("chain trigger did not enable channel");
    a_high_wins: assert property (
        arb_bus.req[0] && arb_bus.req[1] &&
        arb_bus.prio[3:2] > arb_bus.prio[1:0] |-> !arb_bus.grant[0])
        else $error("lower priority channel granted");
    a_event_drop: assert property (
        chan_start_i[1] && !ch_rec[1] && !ch_det[1] |=> !ch_det[1])
        else $error("event recorded while disabled");
    a_off_stops: assert property (!mod_on |=> chan_grant_o == '0)
        else $error("transfer continues while module off");
endmodule : dmc_top

// ---- src/dmc_pkg.sv ----
// dmc_pkg: register map, field positions and bus codes for the dma
// channel control block.
// assumes a 32-bit axi4-lite register bus with aligned word accesses.
package dmc_pkg;
    localparam int unsigned ADDR_W   = 8;
    // byte address = {index, alias op, 2'b00}
    localparam logic [3:0]  IDX_MOD  = 4'h0;
    localparam logic [3:0]  IDX_CH0  = 4'h1;
    localparam logic [3:0]  IDX_STAT = 4'h8;
    localparam logic [3:0]  IDX_MASK = 4'h9;
    localparam logic [1:0]  OP_WR    = 2'h0;
    localparam logic [1:0]  OP_CLR   = 2'h1;
    localparam logic [1:0]  OP_SET   = 2'h2;
    localparam logic [1:0]  OP_INV   = 2'h3;
    // module-wide control fields
    localparam int unsigned MOD_ON   = 15;
    localparam int unsigned MOD_SUSP = 12;
    localparam int unsigned MOD_BUSY = 11;
    localparam logic [31:0] MOD_IMPL = 32'h0000_9800;
    // channel control fields
    localparam int unsigned CH_ACT   = 15;
    localparam int unsigned CH_CSEL  = 8;
    localparam int unsigned CH_EN    = 7;
    localparam int unsigned CH_AED   = 6;
    localparam int unsigned CH_CHN   = 5;
    localparam int unsigned CH_AUTO  = 4;
    localparam int unsigned CH_EDET  = 2;
    localparam int unsigned CH_PRI   = 0;
    localparam logic [15:0] CH_IMPL  = 16'h81f7;
    localparam logic [15:0] CH_RST   = 16'h0000;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    // plain write or clear/set/invert alias, limited to strobed bits
    function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [1:0]  op,
                                                input logic [31:0] sm);
        logic [31:0] v;
        v = wd & sm;
        unique case (op)
            OP_WR:  alias_apply = (old & ~sm) | v;
            OP_CLR: alias_apply = old & ~v;
            OP_SET: alias_apply = old | v;
            OP_INV: alias_apply = old ^ v;
        endcase
    endfunction : alias_apply
endpackage : dmc_pkg

// ---- src/dmc_arb_if.sv ----
// dmc_arb_if: request, priority and grant lines between the control
// core and its channel arbiter.
// assumes both ends agree on the channel count.
`timescale 1ns/1ps
interface dmc_arb_if #(parameter int unsigned NCH = 4);
    logic [NCH-1:0]   req;
    logic [2*NCH-1:0] prio;
    logic [NCH-1:0]   grant;
    modport arb  (input req, input prio, output grant);
    modport user (output req, output prio, input grant);
endinterface : dmc_arb_if

// ---- src/dmc_arbiter.sv ----
// dmc_arbiter: picks one requesting channel, highest priority code
// first, lowest index among equals.
// assumes requests are already gated by module enable and suspend.
`timescale 1ns/1ps
module dmc_arbiter #(
    parameter int unsigned NCH = 4
) (
    dmc_arb_if.arb ab
);
    logic [1:0] maxp;
    logic       found;

    always_comb begin
        maxp = 2'h0;
        for (int i = 0; i < NCH; i++) begin
            if (ab.req[i] && ab.prio[2*i +: 2] > maxp) begin
                maxp = ab.prio[2*i +: 2];
            end
        end
    end

    always_comb begin
        ab.grant = '0;
        found    = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (!found && ab.req[i] && ab.prio[2*i +: 2] == maxp) begin
                ab.grant[i] = 1'b1;
                found       = 1'b1;
            end
        end
    end
endmodule : dmc_arbiter

// ---- src/dmc_channel.sv ----
// dmc_channel: one channel control word with its hardware updates.
// assumes sw_val_i already has the alias operation applied.
`timescale 1ns/1ps
module dmc_channel (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        sw_we_i,
    input  wire logic [15:0] sw_val_i,
    input  wire logic        start_i,
    input  wire logic        abort_i,
    input  wire logic        done_i,
    input  wire logic        chain_trig_i,
    input  wire logic        taken_i,
    input  wire logic        running_i,
    output logic      [15:0] ctrl_o
);
    logic [15:0] r;
    wire         rec      = r[dmc_pkg::CH_EN] | r[dmc_pkg::CH_AED];
    wire         start_ok = start_i & rec;
    wire         abort_ok = abort_i & rec;
    wire  [15:0] base     = sw_we_i ? sw_val_i : r;
    wire         set_en   = chain_trig_i & r[dmc_pkg::CH_CHN];
    wire         clr_en   = (done_i & ~r[dmc_pkg::CH_AUTO]) | abort_ok;
    wire         clr_act  = done_i | abort_ok;
    // a running channel keeps its busy flag only until its block ends
    wire         set_act  = taken_i | (running_i & ~clr_act);
    wire         clr_det  = taken_i | abort_ok;

    // hardware sets win over any clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= dmc_pkg::CH_RST;
        end else begin
            r[dmc_pkg::CH_ACT]  <= set_act |
                (base[dmc_pkg::CH_ACT] & ~clr_act);
            r[14:9]             <= 6'h00;
            r[dmc_pkg::CH_CSEL] <= base[dmc_pkg::CH_CSEL];
            r[dmc_pkg::CH_EN]   <= set_en |
                (base[dmc_pkg::CH_EN] & ~clr_en);
            r[6:4]              <= base[6:4];
            r[3]                <= 1'b0;
            r[dmc_pkg::CH_EDET] <= start_ok |
                (r[dmc_pkg::CH_EDET] & ~clr_det);
            r[1:0]              <= base[1:0];
        end
    end

    assign ctrl_o = r;
endmodule : dmc_channel

// ---- bench/dmc_engine_model.sv ----
// dmc_engine_model: transfer engine that runs the granted channel and
// reports block completion after a programmable number of cycles.
// assumes grant is one-hot and held until the done pulse is seen.
`timescale 1ns/1ps
module dmc_engine_model #(
    parameter int unsigned NCH = 4
) (
    input  wire logic           clk_sys_i,
    input  wire logic           rst_n_i,
    input  wire logic [NCH-1:0] grant_i,
    input  wire logic [7:0]     delay_i,
    output logic      [NCH-1:0] done_o
);
    logic [7:0] cnt;
    // a dropped grant restarts the count, so a stopped block never ends
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt    <= 8'h00;
            done_o <= '0;
        end else begin
            done_o <= '0;
            if (grant_i != '0 && done_o == '0) begin
                if (cnt == delay_i) begin
                    done_o <= grant_i;
                    cnt    <= 8'h00;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end else begin
                cnt <= 8'h00;
            end
        end
    end
endmodule : dmc_engine_model

// ---- bench/tb_top.sv ----
// tb_top: register, transfer, chaining and interrupt tests of dmc_top.
// assumes dmc_pkg, the design and the engine model compile first.
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned NCH = 4;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } dmc_rexp_t;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, module_active_o, irq_o;
    logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0]     dly = 8'h03;
    logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hded0;
    logic [3:0]     s_axi_wstrb = 4'h0;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic [NCH-1:0] chan_start_i = '0, chan_abort_i = '0, chan_done_i;
    logic [NCH-1:0] chan_grant_o, gnt_q = '0;
    dmc_rexp_t      q_rd[$];
    logic [1:0]     q_wr[$];
    logic [31:0]    q_gnt[$];
    int             n_fail = 0, n_compared = 0;
    dmc_top #(.NCH(NCH)) dmc_top_i (.clk_sys_i, .rst_n_i, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .chan_start_i, .chan_abort_i, .chan_done_i, .chan_grant_o,
        .module_active_o, .irq_o);
    dmc_engine_model #(.NCH(NCH)) dmc_engine_model_i (.clk_sys_i,
        .rst_n_i, .grant_i(chan_grant_o), .delay_i(dly),
        .done_o(chan_done_i));
    always #20 clk_sys_i = ~clk_sys_i;
    function automatic logic [7:0] adr(input int i, input logic [1:0] op);
        adr = {4'(i), op, 2'b00};
    endfunction : adr
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs
    task automatic chk_val(input string nm, input logic [31:0] e,
                           input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk_val
    task automatic chk_resp(input string nm, input logic [1:0] e,
                            input logic [1:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk_resp
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = dmc_pkg::RESP_OK);
        logic got;
        got = 1'b0;
        q_wr.push_back(r);
        @(posedge clk_sys_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_bready  <= 1'b1;
        while (!got) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hffffffff,
                      input logic [1:0] r = dmc_pkg::RESP_OK);
        logic got;
        got = 1'b0;
        q_rd.push_back('{d, m, r});
        @(posedge clk_sys_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        while (!got) begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
    endtask : rd
    task automatic kick(input logic [NCH-1:0] s, input logic [NCH-1:0] ab);
        @(posedge clk_sys_i);
        chan_start_i <= s;
        chan_abort_i <= ab;
        @(posedge clk_sys_i);
        chan_start_i <= '0;
        chan_abort_i <= '0;
        repeat (30) @(posedge clk_sys_i);
    endtask : kick
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // bus responses and grants are judged here, in the order the driver noted them
    always @(posedge clk_sys_i) begin : monitor
        dmc_rexp_t e;
        if (s_axi_bvalid && s_axi_bready)
            chk_resp("bresp", q_wr.pop_front(), s_axi_bresp);
        if (s_axi_rvalid && s_axi_rready) begin
            e = q_rd.pop_front();
            chk_val("rdata", e.d & e.m, s_axi_rdata & e.m);
            chk_resp("rresp", e.r, s_axi_rresp);
        end
        if (chan_grant_o !== gnt_q && chan_grant_o !== '0)
            chk_val("grant", q_gnt.pop_front(), 32'(chan_grant_o));
        gnt_q = chan_grant_o;
    end
    initial begin : watchdog
        #(40 * 20000);
        n_fail++;
        conclude();
    end
    initial begin : main
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // indexes past the last channel and below status are unmapped
        for (int k = 0; k < 10; k++) begin
            rd(adr(k, 0), 32'h0, 32'hffffffff, (k > NCH && k < 8) ?
               dmc_pkg::RESP_ERR : dmc_pkg::RESP_OK);
        end
        wr(adr(0, 0), 32'hffffffff);
        rd(adr(0, 0), 32'h00009800);
        wr(adr(0, dmc_pkg::OP_CLR), 32'h1000);
        rd(adr(0, 0), 32'h00008800);
        wr(adr(1, 0), 32'hffffffff);
        rd(adr(1, 0), 32'h000081f3);
        wr(adr(1, 0), 32'h0);
        wr(adr(2, dmc_pkg::OP_SET), 32'h3);
        wr(adr(2, dmc_pkg::OP_INV), 32'h1);
        rd(adr(2, 0), 32'h2);
        wr(adr(2, dmc_pkg::OP_CLR), 32'h2);
        rd(adr(2, 0), 32'h0);
        kick(4'b0010, 4'b0000);
        rd(adr(2, 0), 32'h0, 32'h4);
        wr(adr(2, 0), 32'h40);
        kick(4'b0010, 4'b0000);
        rd(adr(2, 0), 32'h44);
        kick(4'b0000, 4'b0010);
        rd(adr(2, 0), 32'h40, 32'h4);
        for (int au = 0; au < 2; au++) begin
            wr(adr(1, 0), au ? 32'h90 : 32'h80);
            q_gnt.push_back(32'h1);
            kick(4'b0001, 4'b0000);
            rd(adr(1, 0), au ? 32'h80 : 32'h0, 32'h80);
        end
        rd(adr(8, 0), 32'h1, 32'h1);
        wr(adr(9, 0), 32'h1);
        chk_val("irq", 32'h1, 32'(irq_o));
        wr(adr(9, 0), 32'h0);
        chk_val("irq", 32'h0, 32'(irq_o));
        wr(adr(9, 0), 32'h1);
        wr(adr(8, 0), 32'hff);
        chk_val("irq", 32'h0, 32'(irq_o));
        rd(adr(8, 0), 32'h0);
        wr(adr(1, 0), 32'h80);
        wr(adr(2, 0), 32'h83);
        q_gnt.push_back(32'h2);
        q_gnt.push_back(32'h1);
        kick(4'b0011, 4'b0000);
        for (int sel = 0; sel < 2; sel++) begin
            wr(adr(2, 0), sel ? 32'h120 : 32'h020);
            wr(adr(sel ? 3 : 1, 0), 32'h80);
            q_gnt.push_back(sel ? 32'h4 : 32'h1);
            kick(sel ? 4'b0100 : 4'b0001, 4'b0000);
            rd(adr(2, 0), 32'h80, 32'h80);
            wr(adr(2, 0), 32'h0);
        end
        dly <= 8'h50;
        wr(adr(0, dmc_pkg::OP_SET), 32'h1000);
        wr(adr(1, 0), 32'h80);
        kick(4'b0001, 4'b0000);
        chk_val("grant", 32'h0, 32'(chan_grant_o));
        q_gnt.push_back(32'h1);
        wr(adr(0, dmc_pkg::OP_CLR), 32'h1000);
        repeat (5) @(posedge clk_sys_i);
        wr(adr(0, 0), 32'h0);
        // grant drops on the edge that ends the write; look once settled
        @(negedge clk_sys_i);
        chk_val("grant", 32'h0, 32'(chan_grant_o));
        repeat (2) @(posedge clk_sys_i);
        rd(adr(0, 0), 32'h0);
        kick(4'b0001, 4'b0000);
        chk_val("grant", 32'h0, 32'(chan_grant_o));
        chk_val("active", 32'h0, 32'(module_active_o));
        rd(adr(7, 0), 32'h0, 32'hffffffff, dmc_pkg::RESP_ERR);
        wr(adr(7, 0), 32'h1, dmc_pkg::RESP_ERR);
        for (int k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            wr(adr(9, 0), rnd);
            rd(adr(9, 0), rnd, 32'h000000ff);
            wr(adr(4, 0), rnd);
            rd(adr(4, 0), rnd & 32'h000081f3);
        end
        conclude();
    end
endmodule : tb_top
